// [core/pdl_host.sv]
// host end of the two-wire programming link with an avalon register port
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`default_nettype none
module pdl_host #(
  parameter int LINK_DIV = 8,
  parameter int RX_WAIT = 1024
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic link_clock_out,
  input wire logic link_data_io_in,
  output logic link_data_io_out,
  output logic link_data_io_oe
);
  typedef enum logic [2:0] {ST_IDLE, ST_ENA, ST_BRK, ST_GAP, ST_TX, ST_TURN, ST_RX} pdl_state_t;

  localparam logic [15:0] DIV_LAST = 16'(LINK_DIV - 1);
  localparam logic [15:0] DIV_HALF = 16'(LINK_DIV / 2 - 1);
  localparam logic [15:0] WAIT_LAST = 16'(RX_WAIT - 1);

  // ==============================================================
  // link clock divider
  logic [15:0] div_ff;
  logic en_ff;
  logic clk_ff;
  wire fall_tick = en_ff && (div_ff == DIV_LAST);
  wire rise_tick = en_ff && (div_ff == DIV_HALF);
  wire [15:0] div_inc = div_ff + 16'h0001;
  wire [15:0] nxt_div = (!en_ff || fall_tick) ? pdl_pkg::CNT_RESET : div_inc;

  // clock stands low while the link is off so the device times out
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_ff <= pdl_pkg::CNT_RESET;
      clk_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      clk_ff <= rise_tick ? 1'b1 : (fall_tick || !en_ff) ? 1'b0 : clk_ff;
    end
  end

  // ==============================================================
  // data input synchroniser
  logic din_s1_ff;
  logic din_s2_ff;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      din_s1_ff <= 1'b1;
      din_s2_ff <= 1'b1;
    end else begin
      din_s1_ff <= link_data_io_in;
      din_s2_ff <= din_s1_ff;
    end
  end

  // ==============================================================
  // register port decode
  logic ack_ff;
  logic pend_ff;
  logic pend_resp_ff;
  logic [1:0] pend_cmd_ff;
  logic [7:0] pend_byte_ff;
  logic [31:0] rdata_ff;
  logic par_ff;
  logic frm_ff;
  logic brk_ff;
  logic tmo_ff;
  logic rxv_ff;
  logic [7:0] rxd_ff;
  pdl_state_t state_ff;
  wire sel_ctrl = avs_address == pdl_pkg::REG_CTRL;
  wire sel_cmd = avs_address == pdl_pkg::REG_CMD;
  wire sel_tx = avs_address == pdl_pkg::REG_TXDATA;
  wire sel_rx = avs_address == pdl_pkg::REG_RXDATA;
  wire sel_st = avs_address == pdl_pkg::REG_STATUS;
  // a new order is held off by waitrequest while one is still queued
  wire busy_wr = avs_write && (sel_cmd || sel_tx) && pend_ff;
  wire nxt_ack = (avs_read || avs_write) && !ack_ff && !busy_wr;
  wire acc_wr = ack_ff && avs_write;
  wire acc_rd = ack_ff && avs_read;
  wire busy = pend_ff || (state_ff != ST_IDLE);
  wire rx_mode = (state_ff == ST_TURN) || (state_ff == ST_RX);
  wire [31:0] st_word = {26'h0, busy, rx_mode, tmo_ff, brk_ff, frm_ff, par_ff};
  wire [31:0] rx_word = {23'h0, rxv_ff, rxd_ff};
  wire [31:0] ctrl_word = {31'h0, en_ff};
  wire [31:0] nxt_rdata = sel_ctrl ? ctrl_word : sel_rx ? rx_word : sel_st ? st_word : 32'h0;
  assign avs_waitrequest = !ack_ff;
  assign avs_readdata = rdata_ff;

  // ==============================================================
  // link sequencer, next-state logic
  logic [15:0] cnt_ff;
  logic [15:0] low_ff;
  logic [10:0] frame_ff;
  logic [9:0] rsh_ff;
  logic [2:0] kidx_ff;
  logic key_ff;
  logic resp_ff;
  logic second_ff;
  logic idle_ok_ff;
  logic dout_ff;
  logic oe_ff;
  pdl_state_t nxt_state;
  logic [15:0] nxt_cnt;
  logic [10:0] nxt_frame;
  logic [9:0] nxt_rsh;
  logic [2:0] nxt_kidx;
  logic nxt_key;
  logic nxt_resp;
  logic nxt_second;
  logic nxt_idle_ok;
  logic nxt_dout;
  logic nxt_oe;
  logic take;
  logic ev_par;
  logic ev_frm;
  logic ev_tmo;
  logic ev_rx;
  wire [15:0] cnt_inc = cnt_ff + 16'h0001;
  wire [7:0] key_byte = pdl_pkg::KEY_VALUE[{kidx_ff, 3'b000} +: 8];
  wire [7:0] key_next = pdl_pkg::KEY_VALUE[{3'(kidx_ff + 3'h1), 3'b000} +: 8];
  // after ten shifts: first stop bit on top, parity below it, d0 at bit 0
  wire [7:0] rx_byte = rsh_ff[7:0];
  wire rx_par = rsh_ff[8];
  wire rx_stop1 = rsh_ff[9];
  wire [7:0] tx_src = (pend_cmd_ff == pdl_pkg::CMD_KEY) ? key_byte : pend_byte_ff;
  // second stop bit is the one shifted in behind the frame
  wire [10:0] tx_frame = {1'b1, ^tx_src, tx_src, 1'b0};
  wire [10:0] key_frame = {1'b1, ^key_next, key_next, 1'b0};
  wire [10:0] frame_shr = {1'b1, frame_ff[10:1]};
  wire ev_brk = rise_tick && !oe_ff && !din_s2_ff && (low_ff == pdl_pkg::BREAK_BITS - 16'h0001);

  // bits leave at falling edges and are sampled at rising edges
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_frame = frame_ff;
    nxt_rsh = rsh_ff;
    nxt_kidx = kidx_ff;
    nxt_key = key_ff;
    nxt_resp = resp_ff;
    nxt_second = second_ff;
    nxt_idle_ok = idle_ok_ff;
    nxt_dout = dout_ff;
    nxt_oe = oe_ff;
    take = 1'b0;
    ev_par = 1'b0;
    ev_frm = 1'b0;
    ev_tmo = 1'b0;
    ev_rx = 1'b0;
    if (!en_ff) begin
      nxt_state = ST_IDLE;
      nxt_idle_ok = 1'b0;
      nxt_dout = 1'b1;
      nxt_oe = 1'b0;
    end else if (fall_tick) begin
      nxt_cnt = cnt_inc;
      case (state_ff)
        ST_IDLE: begin
          nxt_dout = 1'b1;
          nxt_oe = 1'b1;
          nxt_idle_ok = 1'b1;
          if (pend_ff && idle_ok_ff) begin
            take = 1'b1;
            nxt_cnt = pdl_pkg::CNT_RESET;
            nxt_second = 1'b0;
            nxt_kidx = 3'h0;
            nxt_key = 1'b0;
            nxt_resp = 1'b0;
            if (pend_resp_ff || pend_cmd_ff == 2'h0 || pend_cmd_ff == pdl_pkg::CMD_KEY) begin
              nxt_state = ST_TX;
              nxt_frame = tx_frame;
              nxt_dout = 1'b0;
              nxt_key = pend_cmd_ff == pdl_pkg::CMD_KEY;
              nxt_resp = pend_resp_ff;
            end else if (pend_cmd_ff == pdl_pkg::CMD_ENABLE) begin
              nxt_state = ST_ENA;
            end else begin
              nxt_state = ST_BRK;
              nxt_dout = 1'b0;
            end
          end
        end
        ST_ENA: begin
          if (cnt_ff == pdl_pkg::ENABLE_BITS - 16'h0001) begin
            nxt_state = ST_IDLE;
          end
        end
        ST_BRK: begin
          if (cnt_ff == pdl_pkg::BREAK_BITS - 16'h0001) begin
            nxt_state = second_ff ? ST_IDLE : ST_GAP;
            nxt_dout = 1'b1;
            nxt_idle_ok = 1'b0;
          end
        end
        ST_GAP: begin
          nxt_state = ST_BRK;
          nxt_second = 1'b1;
          nxt_cnt = pdl_pkg::CNT_RESET;
          nxt_dout = 1'b0;
        end
        ST_TX: begin
          nxt_frame = frame_shr;
          nxt_dout = frame_ff[1];
          if (cnt_ff == pdl_pkg::FRAME_BITS) begin
            nxt_cnt = pdl_pkg::CNT_RESET;
            if (key_ff && kidx_ff != pdl_pkg::KEY_LAST) begin
              nxt_kidx = 3'(kidx_ff + 3'h1);
              nxt_frame = key_frame;
              nxt_dout = 1'b0;
            end else if (resp_ff) begin
              nxt_state = ST_TURN;
              nxt_oe = 1'b0;
            end else begin
              nxt_state = ST_IDLE;
              nxt_dout = 1'b1;
              nxt_idle_ok = 1'b0;
            end
          end
        end
        default: begin
          nxt_cnt = cnt_ff;
          nxt_oe = 1'b0;
        end
      endcase
    end else if (rise_tick) begin
      case (state_ff)
        ST_TURN: begin
          nxt_cnt = cnt_inc;
          if (!din_s2_ff) begin
            nxt_state = ST_RX;
            nxt_cnt = pdl_pkg::CNT_RESET;
          end else if (cnt_ff == WAIT_LAST) begin
            nxt_state = ST_IDLE;
            nxt_idle_ok = 1'b0;
            ev_tmo = 1'b1;
          end
        end
        ST_RX: begin
          nxt_cnt = cnt_inc;
          nxt_rsh = {din_s2_ff, rsh_ff[9:1]};
          if (cnt_ff == pdl_pkg::FRAME_BITS - 16'h0001) begin
            ev_par = rx_byte[0] ^ rx_byte[1] ^ rx_byte[2] ^ rx_byte[3] ^ rx_byte[4] ^
                     rx_byte[5] ^ rx_byte[6] ^ rx_byte[7] ^ rx_par;
            ev_frm = !rx_stop1 || !din_s2_ff;
            ev_rx = !ev_par && !ev_frm;
            nxt_state = ST_IDLE;
            nxt_idle_ok = 1'b0;
          end
        end
        default: begin
          nxt_state = state_ff;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= pdl_pkg::CNT_RESET;
      frame_ff <= 11'h7FF;
      rsh_ff <= 10'h000;
      kidx_ff <= 3'h0;
      key_ff <= 1'b0;
      resp_ff <= 1'b0;
      second_ff <= 1'b0;
      idle_ok_ff <= 1'b0;
      dout_ff <= 1'b1;
      oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      frame_ff <= nxt_frame;
      rsh_ff <= nxt_rsh;
      kidx_ff <= nxt_kidx;
      key_ff <= nxt_key;
      resp_ff <= nxt_resp;
      second_ff <= nxt_second;
      idle_ok_ff <= nxt_idle_ok;
      dout_ff <= nxt_dout;
      oe_ff <= nxt_oe;
    end
  end

  // low run counter saturates so a long break counts once
  wire [15:0] low_inc = (low_ff == pdl_pkg::BREAK_BITS) ? low_ff : low_ff + 16'h0001;
  wire [15:0] nxt_low = (oe_ff || din_s2_ff) ? pdl_pkg::CNT_RESET : low_inc;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      low_ff <= pdl_pkg::CNT_RESET;
    end else if (rise_tick || oe_ff) begin
      low_ff <= nxt_low;
    end
  end

  // ==============================================================
  // register file: queued order, sticky flags (set beats clear)
  wire wr_st = acc_wr && sel_st;
  wire [31:0] wd = avs_writedata;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0;
      en_ff <= 1'b0;
      pend_ff <= 1'b0;
      pend_cmd_ff <= 2'h0;
      pend_resp_ff <= 1'b0;
      pend_byte_ff <= pdl_pkg::BYTE_RESET;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_ack ? nxt_rdata : rdata_ff;
      en_ff <= (acc_wr && sel_ctrl) ? wd[pdl_pkg::CTRL_EN_BIT] : en_ff;
      pend_ff <= (acc_wr && (sel_cmd || sel_tx)) || (pend_ff && !take);
      pend_cmd_ff <= (acc_wr && sel_cmd) ? wd[1:0] : (acc_wr && sel_tx) ? 2'h0 : pend_cmd_ff;
      pend_resp_ff <= acc_wr ? (sel_tx && wd[pdl_pkg::TX_RESP_BIT]) : pend_resp_ff;
      pend_byte_ff <= (acc_wr && sel_tx) ? wd[7:0] : pend_byte_ff;
    end
  end

  // status flags; a write of one clears (rx valid: a read of the rx register), a same-cycle event keeps it set
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      par_ff <= 1'b0;
      frm_ff <= 1'b0;
      brk_ff <= 1'b0;
      tmo_ff <= 1'b0;
      rxv_ff <= 1'b0;
      rxd_ff <= pdl_pkg::BYTE_RESET;
    end else begin
      par_ff <= ev_par || (par_ff && !(wr_st && wd[pdl_pkg::ST_PAR_BIT]));
      frm_ff <= ev_frm || (frm_ff && !(wr_st && wd[pdl_pkg::ST_FRM_BIT]));
      brk_ff <= ev_brk || (brk_ff && !(wr_st && wd[pdl_pkg::ST_BRK_BIT]));
      tmo_ff <= ev_tmo || (tmo_ff && !(wr_st && wd[pdl_pkg::ST_TMO_BIT]));
      rxv_ff <= ev_rx || (rxv_ff && !(acc_rd && sel_rx));
      rxd_ff <= ev_rx ? rx_byte : rxd_ff;
    end
  end

  assign link_clock_out = clk_ff;
  assign link_data_io_out = dout_ff;
  assign link_data_io_oe = oe_ff;

  // ==============================================================
  // checks
  wire tx_on = state_ff == ST_TX;
  wire [7:0] tx_data = frame_ff[8:1];
  a_tx_start_low: assert property (@(posedge core_clk) disable iff (!nrst)
    tx_on && cnt_ff == 16'h0 && frame_ff[0] == 1'b0 |-> !dout_ff && oe_ff)
    else $error("start bit not driven low");
  a_tx_stop_high: assert property (@(posedge core_clk) disable iff (!nrst)
    tx_on && cnt_ff >= 16'h000A |-> dout_ff && oe_ff)
    else $error("stop bit not high");
  a_tx_bit_order: assert property (@(posedge core_clk) disable iff (!nrst)
    tx_on |-> dout_ff == frame_ff[0])
    else $error("line differs from frame bit");
  a_tx_par_even: assert property (@(posedge core_clk) disable iff (!nrst)
    tx_on && cnt_ff == 16'h0 |-> frame_ff[9] == ^tx_data)
    else $error("parity bit is not even");
  a_brk_length: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(state_ff == ST_BRK) && en_ff |-> $past(cnt_ff) == 16'h000B && dout_ff)
    else $error("break not twelve bits");
  a_resync_gap: assert property (@(posedge core_clk) disable iff (!nrst)
    state_ff == ST_GAP |-> dout_ff && oe_ff && !second_ff)
    else $error("gap between breaks not high");
  a_enable_len: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(state_ff == ST_ENA) && en_ff |-> $past(cnt_ff) == 16'h000F && dout_ff)
    else $error("enable not sixteen high bits");
  a_change_fall: assert property (@(posedge core_clk) disable iff (!nrst)
    $changed(dout_ff) && $past(en_ff) |-> $past(fall_tick))
    else $error("data changed off falling edge");
  a_idle_first: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(tx_on) |-> $past(dout_ff) && $past(idle_ok_ff))
    else $error("start without a leading idle bit");
  a_key_bytes: assert property (@(posedge core_clk) disable iff (!nrst)
    tx_on && key_ff && cnt_ff == 16'h0 |-> tx_data == key_byte)
    else $error("key byte mismatch");
  a_rx_released: assert property (@(posedge core_clk) disable iff (!nrst)
    state_ff == ST_RX |-> !oe_ff)
    else $error("driving while device answers");
  c_enable: cover property (@(posedge core_clk) disable iff (!nrst) $fell(state_ff == ST_ENA));
  c_resync: cover property (@(posedge core_clk) disable iff (!nrst) $fell(second_ff));
  c_key_done: cover property (@(posedge core_clk) disable iff (!nrst)
    key_ff && kidx_ff == pdl_pkg::KEY_LAST && $fell(tx_on));
  c_rx_byte: cover property (@(posedge core_clk) disable iff (!nrst) ev_rx);
endmodule // pdl_host
`default_nettype wire

// [core/pdl_pkg.sv]
// constants and register map of the programming link host controller
// ==============================================================
package pdl_pkg;
  // ==============================================================
  // frame and character lengths, in bit periods, and the unlock key
  localparam logic [15:0] FRAME_BITS = 16'h000B;
  localparam logic [15:0] BREAK_BITS = 16'h000C;
  localparam logic [15:0] ENABLE_BITS = 16'h0010;
  localparam logic [2:0] KEY_LAST = 3'h7;
  localparam logic [63:0] KEY_VALUE = 64'h1289AB45CDD888FF;
  // ==============================================================
  // timing: core clock rate and slowest legal link clock
  localparam int CORE_HZ = 50000000;
  localparam int MIN_LINK_HZ = 10000;
  localparam int MAX_DIV = CORE_HZ / MIN_LINK_HZ;
  // ==============================================================
  // register word offsets (byte address = 4 * index)
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_CMD = 3'h1;
  localparam logic [2:0] REG_TXDATA = 3'h2;
  localparam logic [2:0] REG_RXDATA = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int TX_RESP_BIT = 8;
  localparam int RX_VALID_BIT = 8;
  localparam int ST_PAR_BIT = 0;
  localparam int ST_FRM_BIT = 1;
  localparam int ST_BRK_BIT = 2;
  localparam int ST_TMO_BIT = 3;
  localparam int ST_RXMODE_BIT = 4;
  localparam int ST_BUSY_BIT = 5;
  // command codes written to the command register
  localparam logic [1:0] CMD_ENABLE = 2'h1;
  localparam logic [1:0] CMD_RESYNC = 2'h2;
  localparam logic [1:0] CMD_KEY = 2'h3;
  // reset values
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage

// [verification/pdl_dev_model.sv]
// behavioural model of the target device at the far end of the link
`timescale 1ns/1ns
`default_nettype none
module pdl_dev_model #(
  parameter int GUARD = 128,
  parameter logic [7:0] KEY_INSTR = 8'hC0,
  parameter logic [7:0] STAT_INSTR = 8'h80
) (
  input wire logic link_clock_in,
  input wire logic line_in,
  input wire logic bad_par,
  input wire logic bad_stop,
  output logic dev_out,
  output logic dev_oe
);
  logic linked_ff = 1'b0;
  logic unlocked_ff = 1'b0;
  logic tx_on_ff = 1'b0;
  logic wait_brk_ff = 1'b0;
  logic cur_ff = 1'b1;
  logic nb;
  logic [10:0] sh_ff;
  logic [11:0] frame_ff;
  logic [63:0] key_ff;
  logic [7:0] got_q[$];
  int lo_run = 0;
  int hi_run = 0;
  int bitn = 0;
  int kcnt = 0;
  int gcnt = 0;
  int fpos = 0;
  int brk_cnt = 0;
  int err_cnt = 0;
  time last_t = 0;

  initial begin
    dev_out = 1'b1;
    dev_oe = 1'b0;
  end

  // ==============================================================
  // frame check and request decode
  task automatic take_frame();
    if (^sh_ff[8:0] || !(sh_ff[9] && sh_ff[10])) begin
      err_cnt++;
    end else if (kcnt > 0) begin
      key_ff = {sh_ff[7:0], key_ff[63:8]};
      kcnt--;
      unlocked_ff = (kcnt == 0 && key_ff == pdl_pkg::KEY_VALUE);
    end else begin
      got_q.push_back(sh_ff[7:0]);
      if (sh_ff[7:0] == KEY_INSTR) kcnt = 8;
      if (sh_ff[7:0] == STAT_INSTR) begin
        // status reply; fault inputs corrupt parity or first stop bit
        frame_ff = {1'b1, !bad_stop, unlocked_ff ^ bad_par, 7'h00, unlocked_ff, 1'b0};
        gcnt = 2 + GUARD;
        fpos = 0;
        cur_ff = 1'b1;
        tx_on_ff = 1'b1;
      end
    end
  endtask

  // ==============================================================
  // sampling on rising edges: enable, breaks, frames, collisions
  always @(posedge link_clock_in) begin
    // a gap beyond 100 us means the clock fell under 10 kHz
    if ($time - last_t > 64'd100000) linked_ff = 1'b0;
    last_t = $time;
    lo_run = line_in ? 0 : lo_run + 1;
    hi_run = line_in ? hi_run + 1 : 0;
    if (hi_run == 16) linked_ff = 1'b1;
    if (tx_on_ff) begin
      // only held bits can be checked, the driver is off then
      if (!dev_oe && line_in != cur_ff) begin
        tx_on_ff = 1'b0;
        wait_brk_ff = 1'b1;
      end
    end else if (lo_run == 12) begin
      brk_cnt++;
      wait_brk_ff = 1'b0;
      bitn = 0;
    end else if (linked_ff && !wait_brk_ff) begin
      if (bitn == 0) begin
        bitn = line_in ? 0 : 1;
      end else begin
        sh_ff[bitn-1] = line_in;
        bitn++;
        if (bitn == 12) begin
          bitn = 0;
          take_frame();
        end
      end
    end
  end

  // ==============================================================
  // driving on falling edges: guard idles, then one frame
  always @(negedge link_clock_in) begin
    if (!tx_on_ff) begin
      dev_oe <= 1'b0;
    end else begin
      if (gcnt > 0) begin
        nb = 1'b1;
        gcnt--;
      end else begin
        nb = frame_ff[fpos];
        fpos++;
        if (fpos == 12) tx_on_ff = 1'b0;
      end
      dev_oe <= (nb != cur_ff);
      dev_out <= nb;
      cur_ff = nb;
    end
  end
endmodule // pdl_dev_model
`default_nettype wire

// [verification/pdl_host_test.sv]
// self-checking bench for the link host controller against the device model
`timescale 1ns/1ns
`default_nettype none
module pdl_host_test;
  localparam logic [7:0] STAT = 8'h80;
  localparam logic [7:0] KEYI = 8'hC0;
  localparam logic [7:0] TX_BYTES [6] = '{8'h00, 8'hFF, 8'h01, 8'h7F, 8'h5A, 8'hA5};
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic link_clock_out;
  logic link_data_io_out;
  logic link_data_io_oe;
  logic dev_out;
  logic dev_oe;
  logic bad_par = 1'b0;
  logic bad_stop = 1'b0;
  logic keep_ff = 1'b1;
  logic lc_ff;
  logic do_ff;
  logic oe_ff;
  logic [31:0] rd;
  wire line;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  // line level: host, then device, else the keeper's last level
  assign line = link_data_io_oe ? link_data_io_out : (dev_oe ? dev_out : keep_ff);

  pdl_host #(.LINK_DIV(8), .RX_WAIT(200)) u_dut (
    .core_clk(core_clk),
    .nrst(nrst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .link_clock_out(link_clock_out),
    .link_data_io_in(line),
    .link_data_io_out(link_data_io_out),
    .link_data_io_oe(link_data_io_oe)
  );

  pdl_dev_model u_dev (
    .link_clock_in(link_clock_out),
    .line_in(line),
    .bad_par(bad_par),
    .bad_stop(bad_stop),
    .dev_out(dev_out),
    .dev_oe(dev_oe)
  );

  always #10 core_clk = ~core_clk;

  // ==============================================================
  // closing report and shared checks
  task automatic stop_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // ==============================================================
  // keeper, edge discipline watch and hang limit
  always @(posedge core_clk) begin
    keep_ff <= line;
    lc_ff <= link_clock_out;
    do_ff <= link_data_io_out;
    oe_ff <= link_data_io_oe;
    cycles <= cycles + 1;
    // a driven bit may only move where the link clock just fell
    if (oe_ff && link_data_io_oe && do_ff !== link_data_io_out && !(lc_ff && !link_clock_out)) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, link_data_io_out, do_ff);
    end
    if (cycles == 40000) begin
      err_count++;
      stop_test();
    end
  end

  // ==============================================================
  // avalon access: hold until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask

  // polls status until the sequencer is idle; rd keeps the last status
  task automatic wait_idle();
    rd = 32'h00000020;
    for (int i = 0; i < 3000 && rd[5] !== 1'b0; i++) bus(1'b0, pdl_pkg::REG_STATUS, 32'h0);
  endtask

  // sends the status request and expects the response register word
  task automatic query(input logic [31:0] exp);
    bus(1'b1, pdl_pkg::REG_TXDATA, {23'h000000, 1'b1, STAT});
    wait_idle();
    bus(1'b0, pdl_pkg::REG_RXDATA, 32'h0);
    check(rd, exp);
  endtask

  // ==============================================================
  // main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, pdl_pkg::REG_RXDATA, 32'h0);
    check(rd, 32'h00000000);
    bus(1'b1, 3'h7, 32'hFFFFFFFF);
    bus(1'b0, 3'h7, 32'h0);
    check(rd, 32'h00000000);
    bus(1'b0, pdl_pkg::REG_STATUS, 32'h0);
    check(rd & 32'h0000002F, 32'h00000000);
    bus(1'b1, pdl_pkg::REG_CTRL, 32'h00000001);
    bus(1'b1, pdl_pkg::REG_CMD, {30'h0, pdl_pkg::CMD_ENABLE});
    wait_idle();
    check({31'h0, u_dev.linked_ff}, 32'h00000001);
    // back-to-back bytes, later writes stall on waitrequest
    foreach (TX_BYTES[i]) bus(1'b1, pdl_pkg::REG_TXDATA, {24'h000000, TX_BYTES[i]});
    wait_idle();
    check(32'(u_dev.got_q.size()), 32'h00000006);
    foreach (TX_BYTES[i]) check({24'h0, u_dev.got_q[i]}, {24'h0, TX_BYTES[i]});
    check(32'(u_dev.err_cnt), 32'h00000000);
    query(32'h00000100);
    bus(1'b1, pdl_pkg::REG_TXDATA, {24'h000000, KEYI});
    bus(1'b1, pdl_pkg::REG_CMD, {30'h0, pdl_pkg::CMD_KEY});
    wait_idle();
    check({31'h0, u_dev.unlocked_ff}, 32'h00000001);
    query(32'h00000101);
    bus(1'b0, pdl_pkg::REG_RXDATA, 32'h0);
    check(rd, 32'h00000001);
    // corrupted replies must raise flags and leave the data invalid
    bad_par <= 1'b1;
    query(32'h00000001);
    bus(1'b0, pdl_pkg::REG_STATUS, 32'h0);
    check(rd & 32'h0000000F, 32'h00000001);
    bus(1'b1, pdl_pkg::REG_STATUS, 32'h0000000F);
    bad_par <= 1'b0;
    bad_stop <= 1'b1;
    query(32'h00000001);
    bus(1'b0, pdl_pkg::REG_STATUS, 32'h0);
    check(rd & 32'h0000000F, 32'h00000002);
    bad_stop <= 1'b0;
    bus(1'b1, pdl_pkg::REG_STATUS, 32'h0000000F);
    bus(1'b0, pdl_pkg::REG_STATUS, 32'h0);
    check(rd & 32'h0000000F, 32'h00000000);
    // silent request while a reply is expected ends in a timeout
    bus(1'b1, pdl_pkg::REG_TXDATA, 32'h00000111);
    wait_idle();
    check(rd & 32'h0000000F, 32'h00000008);
    n = u_dev.brk_cnt;
    bus(1'b1, pdl_pkg::REG_CMD, {30'h0, pdl_pkg::CMD_RESYNC});
    wait_idle();
    check(32'(u_dev.brk_cnt), 32'(n + 2));
    stop_test();
  end
endmodule // pdl_host_test
`default_nettype wire
